// [hdl/floppy_status_reset_mode.sv]
// Function
// [RULE_01] Set status-two bit 6 when read meets the opposite data mark kind.
// [RULE_02] Set status-two bit 5 on data field checksum mismatch.
// [RULE_03] Set status-two bit 4 when ID track differs from internal track.
// [RULE_04] Set status-two bit 1 when ID track differs and equals FF.
// [RULE_05] Set status-two bit 0 when no data or deleted-data mark found.
// [RULE_06] Status-two bits 7,3,2 and status-three bit 7 always zero.
// [RULE_07] Status-three bits 5 and 3 always one.
// [RULE_08] Status-three bit 6 mirrors write protect, bit 4 track zero.
// [RULE_09] Status-three bit 2 mirrors head select, bits 1,0 drive selects.
// [RULE_10] Pin, output-register and data-rate resets all act and end power-down.
// [RULE_11] Any reset aborts operations and returns to idle.
// [RULE_12] Leaving reset clears configure settings, waits, and restarts polling.
// [RULE_13] Pin reset clears everything except specify-command values.
// [RULE_14] Pin reset sets output-register reset bit; host must clear it.
// [RULE_15] Data-rate reset self-clears; output-register reset holds and has precedence.
// [RULE_16] Software resets reset core, drive status and FIFO logic.
// [RULE_17] Mode comes from configuration register 3 bits 6 and 5.
// [RULE_18] Identity high: DMA enable valid, pins may float, TC and density high.
// [RULE_19] Identity low, variant high: enable ignored, pins driven, TC, density low.
// [RULE_20] Both low: enable valid, pins may float, TC high, density low.
// [RULE_21] Specify-enabled DMA raises request; acknowledge alone reaches the FIFO.
// [RULE_22] Verify pseudo read on acknowledge only with FIFO off and read active.
// [RULE_23] Density pin high after pin reset, untouched by software resets.
// [RULE_24] Status bytes are returned as result-phase data register reads.
`timescale 1ns/1ps
`default_nettype none
module floppy_status_reset_mode
  import fdc_status_pkg::*;
(
  // Clock and resets
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic power_on_resetn,
  // Host register writes
  input wire logic digital_output_reg_wr,
  input wire logic dsr_wr,
  input wire logic cfg3_wr,
  input wire logic [7:0] host_wdata,
  // Command engine events
  input wire logic specify_wr,
  input wire logic specify_dma,
  input wire logic configure_wr,
  input wire logic configure_fifo_en,
  input wire logic configure_poll_dis,
  input wire logic cmd_start,
  input wire logic cmd_done,
  input wire logic read_cmd_active,
  input wire logic read_deleted_cmd,
  input wire logic mark_seen,
  input wire logic mark_deleted,
  input wire logic data_crc_err,
  input wire logic id_valid,
  input wire logic [7:0] id_track,
  input wire logic [7:0] cur_track,
  input wire logic mark_missing,
  input wire logic xfer_req,
  input wire logic int_req,
  // Result reads
  input wire logic result_rd,
  input wire logic result_sel,
  output logic [7:0] result_data_q,
  output logic result_valid_q,
  // Drive pins
  input wire logic write_protect_pin,
  input wire logic track_zero_pin,
  input wire logic head_select_pin,
  input wire logic [1:0] drive_select_pin,
  output logic density_select_pin_q,
  // Host side pins
  input wire logic tc_pin,
  input wire logic dack_n,
  input wire logic verify_cycle,
  output logic floppy_interrupt_q,
  output logic floppy_interrupt_oe_q,
  output logic floppy_dma_request_q,
  output logic floppy_dma_request_oe_q,
  // Core status
  output logic core_reset_q,
  output logic power_down_q,
  output logic op_active_q,
  output logic poll_enable_q,
  output logic fifo_enable_q,
  output logic fifo_access_q,
  output logic tc_seen_q,
  output logic pseudo_read_q,
  output logic verify_refused_q
);

  // Register state
  logic outreg_reset_q, outreg_reset_d;
  logic outreg_dma_q, outreg_dma_d;
  logic dsr_reset_q, dsr_reset_d;
  logic [1:0] rate_q, rate_d;
  logic [7:0] cfg3_q, cfg3_d;
  logic specify_dma_q, specify_dma_d;
  logic density_d, power_down_d, core_reset_d;
  logic op_active_d, poll_enable_d, fifo_enable_d;
  op_mode_t mode;
  mode_ctl_t mctl;
  logic soft_reset, any_reset, dma_allowed, tc_active, high_density;

  // Mode decode
  always_comb
  begin
    if (cfg3_q[CFG3_IDENT_BIT]) // RULE_17
      mode = MODE_IDENT;
    else if (cfg3_q[CFG3_VARIANT_BIT])
      mode = MODE_VARIANT;
    else
      mode = MODE_PLAIN;
    case (mode)
      MODE_IDENT: mctl = '{int_oe: 1'b0, drq_oe: 1'b0, tc_active_high: 1'b1,
                        density_active_high: 1'b1, dma_bit_valid: 1'b1}; // RULE_18
      MODE_VARIANT: mctl = '{int_oe: 1'b1, drq_oe: 1'b1, tc_active_high: 1'b0,
                         density_active_high: 1'b0, dma_bit_valid: 1'b0}; // RULE_19
      MODE_PLAIN: mctl = '{int_oe: 1'b0, drq_oe: 1'b0, tc_active_high: 1'b1,
                         density_active_high: 1'b0, dma_bit_valid: 1'b1}; // RULE_20
      default: mctl = '{int_oe: 1'b0, drq_oe: 1'b0, tc_active_high: 1'b1,
                        density_active_high: 1'b1, dma_bit_valid: 1'b1};
    endcase
  end

  // Reset sources
  always_comb
  begin
    soft_reset = outreg_reset_q || dsr_reset_q; // RULE_16
    any_reset = !resetn || soft_reset; // RULE_10
    outreg_reset_d = outreg_reset_q;
    outreg_dma_d = outreg_dma_q;
    dsr_reset_d = 1'b0; // RULE_15
    rate_d = rate_q;
    cfg3_d = cfg3_q;
    if (digital_output_reg_wr)
    begin
      outreg_reset_d = !host_wdata[OUTREG_RESET_BIT]; // RULE_14
      outreg_dma_d = host_wdata[OUTREG_DMA_BIT];
    end
    if (dsr_wr)
    begin
      dsr_reset_d = host_wdata[DSR_RESET_BIT];
      rate_d = host_wdata[DSR_RATE_LO +: 2];
    end
    if (cfg3_wr)
      cfg3_d = host_wdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      outreg_reset_q <= 1'b1; // RULE_14
      outreg_dma_q <= 1'b0;
      dsr_reset_q <= 1'b0;
      rate_q <= RATE_RESET;
      cfg3_q <= CFG3_RESET; // RULE_13
    end
    else
    begin
      outreg_reset_q <= outreg_reset_d;
      outreg_dma_q <= outreg_dma_d;
      dsr_reset_q <= dsr_reset_d;
      rate_q <= rate_d;
      cfg3_q <= cfg3_d;
    end
  end

  // Specify values survive the pin reset
  always_comb
  begin
    specify_dma_d = specify_wr ? specify_dma : specify_dma_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!power_on_resetn)
      specify_dma_q <= 1'b0;
    else
      specify_dma_q <= specify_dma_d; // RULE_13
  end

  // Core state: abort, power-down, configure settings
  always_comb
  begin
    core_reset_d = soft_reset; // RULE_15
    op_active_d = op_active_q;
    poll_enable_d = poll_enable_q;
    fifo_enable_d = fifo_enable_q;
    power_down_d = power_down_q;
    if (dsr_wr && host_wdata[DSR_PWRDN_BIT])
      power_down_d = 1'b1;
    if (cmd_start)
      op_active_d = 1'b1;
    if (cmd_done)
      op_active_d = 1'b0;
    if (configure_wr)
    begin
      fifo_enable_d = configure_fifo_en;
      poll_enable_d = !configure_poll_dis;
    end
    if (soft_reset)
    begin
      op_active_d = 1'b0; // RULE_11
      power_down_d = 1'b0; // RULE_10
      fifo_enable_d = 1'b0; // RULE_12
      poll_enable_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      core_reset_q <= 1'b1;
      op_active_q <= 1'b0; // RULE_11
      power_down_q <= 1'b0;
      fifo_enable_q <= 1'b0; // RULE_12
      poll_enable_q <= 1'b1;
    end
    else
    begin
      core_reset_q <= core_reset_d;
      op_active_q <= op_active_d;
      power_down_q <= power_down_d;
      fifo_enable_q <= fifo_enable_d;
      poll_enable_q <= poll_enable_d;
    end
  end

  // Density pin follows rate writes only
  always_comb
  begin
    high_density = (rate_d != RATE_RESET);
    density_d = density_select_pin_q;
    if (dsr_wr)
      density_d = mctl.density_active_high ? high_density : !high_density;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      density_select_pin_q <= 1'b1; // RULE_23
    else
      density_select_pin_q <= density_d;
  end

  // DMA, interrupt, acknowledge and verify
  logic drq_d, int_d, drq_oe_d, int_oe_d, fifo_acc_d, tc_seen_d, pseudo_d, refused_d;
  always_comb
  begin
    dma_allowed = specify_dma_q && (!mctl.dma_bit_valid || outreg_dma_q);
    tc_active = mctl.tc_active_high ? tc_pin : !tc_pin;
    drq_d = dma_allowed && xfer_req && op_active_q && !any_reset; // RULE_21
    int_d = int_req && !any_reset;
    drq_oe_d = mctl.drq_oe || outreg_dma_q; // RULE_18
    int_oe_d = mctl.int_oe || outreg_dma_q;
    fifo_acc_d = !dack_n && floppy_dma_request_q && !verify_cycle; // RULE_21
    tc_seen_d = tc_active && !dack_n;
    pseudo_d = 1'b0;
    refused_d = 1'b0;
    if (!dack_n && verify_cycle && floppy_dma_request_q)
    begin
      if (!fifo_enable_q && read_cmd_active) // RULE_22
        pseudo_d = 1'b1;
      else
        refused_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      floppy_dma_request_q <= 1'b0;
      floppy_interrupt_q <= 1'b0;
      floppy_dma_request_oe_q <= 1'b0;
      floppy_interrupt_oe_q <= 1'b0;
      fifo_access_q <= 1'b0;
      tc_seen_q <= 1'b0;
      pseudo_read_q <= 1'b0;
      verify_refused_q <= 1'b0;
    end
    else
    begin
      floppy_dma_request_q <= drq_d;
      floppy_interrupt_q <= int_d;
      floppy_dma_request_oe_q <= drq_oe_d;
      floppy_interrupt_oe_q <= int_oe_d;
      fifo_access_q <= fifo_acc_d;
      tc_seen_q <= tc_seen_d;
      pseudo_read_q <= pseudo_d;
      verify_refused_q <= refused_d;
    end
  end

  // Status byte two flags
  status_two_t st2_set, st2_q;
  status_three_t st3;
  logic [7:0] st2_flags;
  logic track_mismatch;
  always_comb
  begin
    track_mismatch = id_valid && (id_track != cur_track);
    st2_set = '0;
    st2_set.control_mark = mark_seen && (mark_deleted != read_deleted_cmd); // RULE_01
    st2_set.data_field_crc_error = data_crc_err; // RULE_02
    st2_set.wrong_track_flag = track_mismatch; // RULE_03
    st2_set.bad_track_flag = track_mismatch && (id_track == BAD_TRACK_ID); // RULE_04
    st2_set.missing_data_mark_flag = mark_missing; // RULE_05
  end

  status_flag_accum u_st2
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(cmd_start || soft_reset),
    .set_vec(st2_set),
    .zero_mask(ST2_ZERO_MASK), // RULE_06
    .flags_q(st2_flags)
  );

  // Status byte three mirrors the pins
  logic [7:0] result_d;
  always_comb
  begin
    st2_q = status_two_t'(st2_flags);
    st3 = status_three_t'(ST3_ONE_BITS); // RULE_07
    st3.unused7 = 1'b0; // RULE_06
    st3.write_protect_flag = write_protect_pin; // RULE_08
    st3.track_zero_flag = track_zero_pin; // RULE_08
    st3.head_flag = head_select_pin; // RULE_09
    st3.drive_select_status = drive_select_pin; // RULE_09
    result_d = result_sel ? st3 : st2_q; // RULE_24
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      result_data_q <= 8'h00;
      result_valid_q <= 1'b0;
    end
    else
    begin
      result_data_q <= result_rd ? result_d : result_data_q;
      result_valid_q <= result_rd;
    end
  end

  // Checks
  a_crc_flag_sets: assert property (@(posedge clk_sys) disable iff (!resetn)
    data_crc_err ##1 (!cmd_start && !soft_reset) ##1 (result_rd && !result_sel) |=> result_data_q[5]) // RULE_02
    else $error("crc flag missing");
  a_bad_track: assert property (@(posedge clk_sys) disable iff (!resetn)
    (id_valid && id_track == BAD_TRACK_ID && cur_track != BAD_TRACK_ID) |=> st2_flags[1] && st2_flags[4]) // RULE_04
    else $error("bad track flag missing");
  a_st2_zero_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    (st2_flags & ST2_ZERO_MASK) == 8'h00) // RULE_06
    else $error("status two reserved bit set");
  a_st3_fixed: assert property (@(posedge clk_sys) disable iff (!resetn)
    (result_rd && result_sel) |=> result_data_q[5] && result_data_q[3] && !result_data_q[7]) // RULE_07
    else $error("status three fixed bits wrong");
  a_st3_pins: assert property (@(posedge clk_sys) disable iff (!resetn)
    (result_rd && result_sel) |=> result_data_q[6] == $past(write_protect_pin)
      && result_data_q[1:0] == $past(drive_select_pin)) // RULE_08
    else $error("status three pin mirror wrong");
  a_dsr_self_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    dsr_reset_q && !dsr_wr |=> !dsr_reset_q) // RULE_15
    else $error("data rate reset stuck");
  a_outreg_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
    outreg_reset_q && !digital_output_reg_wr |=> outreg_reset_q ##1 core_reset_q) // RULE_14
    else $error("output register reset released alone");
  a_reset_aborts: assert property (@(posedge clk_sys) disable iff (!resetn)
    soft_reset |=> !op_active_q && !power_down_q && poll_enable_q && !fifo_enable_q) // RULE_11
    else $error("reset did not abort");
  a_variant_drives: assert property (@(posedge clk_sys) disable iff (!resetn)
    (mode == MODE_VARIANT) [*2] |-> floppy_dma_request_oe_q && floppy_interrupt_oe_q) // RULE_19
    else $error("pins float in always-driven mode");
  a_drq_needs_dma: assert property (@(posedge clk_sys) disable iff (!resetn)
    floppy_dma_request_q |-> $past(specify_dma_q) && $past(op_active_q)) // RULE_21
    else $error("request without dma enable");
  a_pseudo_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
    pseudo_read_q |-> !$past(fifo_enable_q) && $past(read_cmd_active)) // RULE_22
    else $error("pseudo read when not allowed");
  a_density_soft: assert property (@(posedge clk_sys) disable iff (!resetn)
    (soft_reset && !dsr_wr) |=> $stable(density_select_pin_q)) // RULE_23
    else $error("density changed by software reset");

  c_dsr_reset: cover property (@(posedge clk_sys) disable iff (!resetn) dsr_wr && host_wdata[DSR_RESET_BIT]);
  c_dma_access: cover property (@(posedge clk_sys) disable iff (!resetn) fifo_access_q);
  c_pseudo_read: cover property (@(posedge clk_sys) disable iff (!resetn) pseudo_read_q);
  c_control_mark: cover property (@(posedge clk_sys) disable iff (!resetn) st2_flags[6] ##1 result_valid_q);

endmodule
`default_nettype wire

// [hdl/fdc_status_pkg.sv]
package fdc_status_pkg;

  // Register field positions
  localparam int OUTREG_DRIVE_LO = 0;
  localparam int OUTREG_RESET_BIT = 2;
  localparam int OUTREG_DMA_BIT = 3;
  localparam int DSR_RATE_LO = 0;
  localparam int DSR_PWRDN_BIT = 6;
  localparam int DSR_RESET_BIT = 7;
  localparam int CFG3_VARIANT_BIT = 5;
  localparam int CFG3_IDENT_BIT = 6;

  // Reset values and bad track ID
  localparam logic [7:0] CFG3_RESET = 8'h40;
  localparam logic [1:0] RATE_RESET = 2'h2;
  localparam logic [7:0] BAD_TRACK_ID = 8'hFF;

  // Status byte 2 and 3 fixed patterns
  localparam logic [7:0] ST2_ZERO_MASK = 8'h8C;
  localparam logic [7:0] ST3_ONE_BITS = 8'h28;

  typedef enum logic [2:0] {
    MODE_IDENT = 3'h1,
    MODE_VARIANT = 3'h2,
    MODE_PLAIN = 3'h4
  } op_mode_t;

  typedef struct packed {
    logic unused7;
    logic control_mark;
    logic data_field_crc_error;
    logic wrong_track_flag;
    logic unused3;
    logic unused2;
    logic bad_track_flag;
    logic missing_data_mark_flag;
  } status_two_t;

  typedef struct packed {
    logic unused7;
    logic write_protect_flag;
    logic one5;
    logic track_zero_flag;
    logic one3;
    logic head_flag;
    logic [1:0] drive_select_status;
  } status_three_t;

  typedef struct packed {
    logic int_oe;
    logic drq_oe;
    logic tc_active_high;
    logic density_active_high;
    logic dma_bit_valid;
  } mode_ctl_t;

endpackage

// [hdl/status_flag_accum.sv]
`timescale 1ns/1ps
`default_nettype none
module status_flag_accum
  import fdc_status_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Flag control
  input wire logic clear,
  input wire logic [7:0] set_vec,
  input wire logic [7:0] zero_mask,
  // Flag state
  output logic [7:0] flags_q
);

  logic [7:0] flags_d;

  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_flag
      // Set wins over clear so a same-cycle event is kept
      always_comb
      begin
        if (zero_mask[i])
          flags_d[i] = 1'b0;
        else if (set_vec[i])
          flags_d[i] = 1'b1;
        else if (clear)
          flags_d[i] = 1'b0;
        else
          flags_d[i] = flags_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      flags_q <= 8'h00;
    else
      flags_q <= flags_d;
  end

endmodule
`default_nettype wire

// [tb/dma_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dma_host_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Request from the block
  input wire logic dma_req,
  input wire logic dma_req_oe,
  input wire logic [3:0] ack_delay,
  // Acknowledge back to the block
  output logic dack_n = 1'b1
);
  int wait_n = 0;

  // Acknowledge alone, no address phase; one cycle per granted byte
  always @(negedge clk_sys)
  begin
    if (!resetn || dack_n == 1'b0)
    begin
      dack_n <= 1'b1;
      wait_n <= 0;
    end
    else if (dma_req === 1'b1 && dma_req_oe === 1'b1)
    begin
      if (wait_n >= int'(ack_delay))
        dack_n <= 1'b0;
      else
        wait_n <= wait_n + 1;
    end
    else
      wait_n <= 0;
  end
endmodule
`default_nettype wire

// [tb/floppy_status_reset_mode_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module floppy_status_reset_mode_tb;
  import fdc_status_pkg::*;
  localparam logic [11:0] OUTR = 12'h001, DSR = 12'h002, CFG = 12'h004, SPEC = 12'h008, CONF = 12'h010;
  localparam logic [11:0] START = 12'h020, DONE = 12'h040, MARK = 12'h080, CRC = 12'h100, IDV = 12'h200;
  localparam logic [11:0] MISS = 12'h400, RD = 12'h800;
  localparam logic [7:0] CFGV [3] = '{8'h40, 8'h20, 8'h00};
  localparam logic DRV [3] = '{1'b0, 1'b1, 1'b0};
  localparam logic DHI [3] = '{1'b1, 1'b0, 1'b0};
  localparam logic TCON [3] = '{1'b1, 1'b0, 1'b1};
  logic clk_sys = 1'b0, resetn = 1'b0, por_n = 1'b0, fifo_en = 1'b0, poll_dis = 1'b0, rd_act = 1'b0;
  logic rd_del = 1'b0, mdel = 1'b0, xfer = 1'b0, sel = 1'b0, wp = 1'b0, trk_z = 1'b0, hsel = 1'b0, tc = 1'b0;
  logic vfy = 1'b0, spec_dma = 1'b1;
  logic [1:0] ds = 2'h0;
  logic [7:0] wdata = 8'h00, id_trk = 8'h00;
  logic [11:0] strb = 12'h000;
  logic [3:0] ack_delay = 4'h0;
  logic dack_n, rvalid, dens, fint, fint_oe, drq, drq_oe, core_rst, pdn, op_act, poll_en, fifo_on;
  logic facc, tcs, pseudo, refused;
  logic [7:0] rdata;
  int mismatches = 0, n_compared = 0, cyc = 0;
  int cnt [4], base [4], dl [4];

  floppy_status_reset_mode uut (.clk_sys(clk_sys), .resetn(resetn), .power_on_resetn(por_n),
    .digital_output_reg_wr(strb[0]), .dsr_wr(strb[1]), .cfg3_wr(strb[2]), .host_wdata(wdata),
    .specify_wr(strb[3]), .specify_dma(spec_dma), .configure_wr(strb[4]), .configure_fifo_en(fifo_en),
    .configure_poll_dis(poll_dis),
    .cmd_start(strb[5]), .cmd_done(strb[6]), .read_cmd_active(rd_act), .read_deleted_cmd(rd_del),
    .mark_seen(strb[7]), .mark_deleted(mdel), .data_crc_err(strb[8]), .id_valid(strb[9]), .id_track(id_trk),
    .cur_track(8'h05), .mark_missing(strb[10]), .xfer_req(xfer), .int_req(1'b1), .result_rd(strb[11]),
    .result_sel(sel), .result_data_q(rdata), .result_valid_q(rvalid), .write_protect_pin(wp),
    .track_zero_pin(trk_z), .head_select_pin(hsel), .drive_select_pin(ds), .density_select_pin_q(dens),
    .tc_pin(tc), .dack_n(dack_n), .verify_cycle(vfy), .floppy_interrupt_q(fint),
    .floppy_interrupt_oe_q(fint_oe), .floppy_dma_request_q(drq), .floppy_dma_request_oe_q(drq_oe),
    .core_reset_q(core_rst), .power_down_q(pdn), .op_active_q(op_act), .poll_enable_q(poll_en),
    .fifo_enable_q(fifo_on), .fifo_access_q(facc), .tc_seen_q(tcs), .pseudo_read_q(pseudo),
    .verify_refused_q(refused));

  dma_host_model host (.clk_sys(clk_sys), .resetn(resetn), .dma_req(drq), .dma_req_oe(drq_oe),
    .ack_delay(ack_delay), .dack_n(dack_n));

  always #2.5 clk_sys = ~clk_sys;

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Pulse counters and hang guard
  always @(posedge clk_sys)
  begin
    cnt[0] <= cnt[0] + int'(facc);
    cnt[1] <= cnt[1] + int'(tcs);
    cnt[2] <= cnt[2] + int'(pseudo);
    cnt[3] <= cnt[3] + int'(refused);
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic pulse(input logic [11:0] m, input logic [7:0] d);
    @(negedge clk_sys);
    strb = m;
    wdata = d;
    @(negedge clk_sys);
    strb = 12'h000;
  endtask

  task automatic rd_chk(input logic s, input logic [7:0] exp);
    int k;
    k = 0;
    sel = s;
    pulse(RD, 8'h00);
    while (rvalid !== 1'b1 && k < 4)
    begin
      @(negedge clk_sys);
      k++;
    end
    chk_bit(rvalid, 1'b1);
    chk(rdata, exp);
  endtask

  task automatic st2(input logic [11:0] m, input logic md, input logic rdl, input logic [7:0] idt,
                     input logic [7:0] exp);
    pulse(START, 8'h00);
    mdel = md;
    rd_del = rdl;
    id_trk = idt;
    pulse(m, 8'h00);
    rd_chk(1'b0, exp);
  endtask

  task automatic win(input int n);
    base = cnt;
    idle(n);
    foreach (dl[j])
      dl[j] = cnt[j] - base[j];
  endtask

  task automatic hw_reset;
    resetn = 1'b0;
    idle(4);
    resetn = 1'b1;
    idle(1);
  endtask

  initial
  begin
    int i;
    hw_reset();
    por_n = 1'b1;
    chk_bit(dens, 1'b1);
    chk_bit(poll_en, 1'b1);
    chk_bit(core_rst, 1'b1);
    chk_bit(op_act, 1'b0);
    chk_bit(fint, 1'b0);
    pulse(SPEC, 8'h00);
    pulse(OUTR, 8'h04);
    chk_bit(core_rst, 1'b1);
    idle(1);
    chk_bit(core_rst, 1'b0);
    hw_reset();
    chk_bit(core_rst, 1'b1);
    pulse(OUTR, 8'h04);
    idle(2);
    $display("test reset done");
    for (i = 0; i < 32; i++)
    begin
      {wp, trk_z, hsel, ds} = i[4:0];
      rd_chk(1'b1, {1'b0, i[4], 1'b1, i[3], 1'b1, i[2], i[1:0]});
    end
    $display("test status three done");
    st2(MARK, 1'b1, 1'b0, 8'h05, 8'h40);
    st2(MARK, 1'b0, 1'b1, 8'h05, 8'h40);
    st2(MARK, 1'b1, 1'b1, 8'h05, 8'h00);
    st2(CRC, 1'b0, 1'b0, 8'h05, 8'h20);
    st2(IDV, 1'b0, 1'b0, 8'h07, 8'h10);
    st2(IDV, 1'b0, 1'b0, 8'hFF, 8'h12);
    st2(IDV, 1'b0, 1'b0, 8'h05, 8'h00);
    st2(MISS | CRC, 1'b0, 1'b0, 8'h05, 8'h21);
    id_trk = 8'hFF;
    pulse(IDV, 8'h00);
    rd_chk(1'b0, 8'h33);
    pulse(CRC, 8'h00);
    pulse(DSR, 8'h80);
    idle(3);
    rd_chk(1'b0, 8'h00);
    $display("test status two done");
    fifo_en = 1'b1;
    poll_dis = 1'b1;
    pulse(CONF, 8'h00);
    pulse(DSR, 8'h40);
    pulse(START, 8'h00);
    idle(1);
    chk_bit(pdn, 1'b1);
    chk_bit(fifo_on, 1'b1);
    chk_bit(poll_en, 1'b0);
    pulse(DSR, 8'h80);
    idle(1);
    chk_bit(core_rst, 1'b1);
    chk_bit(pdn, 1'b0);
    chk_bit(op_act, 1'b0);
    chk_bit(fifo_on, 1'b0);
    chk_bit(poll_en, 1'b1);
    idle(1);
    chk_bit(core_rst, 1'b0);
    fifo_en = 1'b0;
    poll_dis = 1'b0;
    pulse(OUTR, 8'h00);
    pulse(DSR, 8'h80);
    idle(4);
    chk_bit(core_rst, 1'b1);
    pulse(OUTR, 8'h04);
    idle(2);
    chk_bit(core_rst, 1'b0);
    $display("test soft reset done");
    xfer = 1'b1;
    for (i = 0; i < 3; i++)
    begin
      ack_delay = 4'(i * 3);
      tc = ~TCON[i];
      pulse(CFG, CFGV[i]);
      pulse(OUTR, 8'h04);
      pulse(DSR, 8'h00);
      pulse(START, 8'h00);
      win(12);
      chk_bit(drq_oe, DRV[i]);
      chk_bit(fint_oe, DRV[i]);
      chk_bit(fint, 1'b1);
      chk_bit(dens, DHI[i]);
      chk_bit(dl[0] != 0, DRV[i]);
      pulse(OUTR, 8'h0C);
      win(12);
      chk_bit(drq_oe, 1'b1);
      chk_bit(dl[0] != 0, 1'b1);
      chk_bit(dl[1] != 0, 1'b0);
      tc = TCON[i];
      win(12);
      chk_bit(dl[1] != 0, 1'b1);
      tc = ~TCON[i];
      pulse(DONE, 8'h00);
    end
    spec_dma = 1'b0;
    pulse(SPEC, 8'h00);
    pulse(START, 8'h00);
    win(12);
    chk_bit(drq, 1'b0);
    chk_bit(dl[0] != 0, 1'b0);
    pulse(DONE, 8'h00);
    spec_dma = 1'b1;
    pulse(SPEC, 8'h00);
    $display("test modes done");
    pulse(START, 8'h00);
    rd_act = 1'b1;
    vfy = 1'b1;
    win(12);
    chk_bit(dl[2] != 0, 1'b1);
    chk_bit(dl[0] != 0, 1'b0);
    fifo_en = 1'b1;
    pulse(CONF, 8'h00);
    win(12);
    chk_bit(dl[3] != 0, 1'b1);
    chk_bit(dl[2] != 0, 1'b0);
    chk_bit(op_act, 1'b1);
    pulse(DSR, 8'h80);
    idle(3);
    chk_bit(op_act, 1'b0);
    chk_bit(drq, 1'b0);
    chk_bit(dens, 1'b0);
    hw_reset();
    chk_bit(dens, 1'b1);
    $display("test verify done");
    close_out();
  end
endmodule
`default_nettype wire
